// ### logic/pic_cpu_end.sv
// Core end: takes interrupts at instruction boundaries and forwards register access.
`timescale 1ns/1ps
module pic_cpu_end (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  sys_rst,
   // Link to the controller
   pic_if.cpu         ctl,
   // Sequencer side
   input  wire logic  seqInstrEnd,
   input  wire logic  seqReti,
   // Software register access
   input  wire logic  swWr,
   input  wire logic  [7:0] swAddr,
   input  wire logic  [7:0] swWdata,
   // Results
   output logic        callGo,
   output logic [15:0] callAddr,
   output logic [7:0]  swRdata
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic              ack;
      pic_pkg::pic_src_t ackSrc;
      logic              return_from_interrupt;
      logic              sfrWr;
      logic [7:0]        sfrAddr;
      logic [7:0]        sfrWdata;
      logic              callGo;
      logic [15:0]       callAddr;
      logic [7:0]        rdata;
   } pic_cpu_state_t;

   pic_cpu_state_t q;
   pic_cpu_state_t d;
   logic           take;

   always_comb
   begin
      d = q;
      // The request seen during an acknowledge is stale, so it is skipped.
      take       = seqInstrEnd && ctl.irqReq && !q.ack;
      d.ack      = take;
      d.callGo   = take;
      if (take)
      begin
         d.ackSrc   = ctl.irqSrc;
         d.callAddr = ctl.irqVector;
      end
      d.return_from_interrupt     = seqReti;
      // Software clears non-auto flags through this path.
      d.sfrWr    = swWr;
      d.sfrAddr  = swAddr;
      d.sfrWdata = swWdata;
      d.rdata    = ctl.sfrRdata;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         q <= '0;
      else
         q <= d;
   end

   assign ctl.irqAck   = q.ack;
   assign ctl.ackSrc   = q.ackSrc;
   assign ctl.retiExec = q.return_from_interrupt;
   assign ctl.sfrWr    = q.sfrWr;
   assign ctl.sfrAddr  = q.sfrAddr;
   assign ctl.sfrWdata = q.sfrWdata;
   assign callGo       = q.callGo;
   assign callAddr     = q.callAddr;
   assign swRdata      = q.rdata;

endmodule : pic_cpu_end

// ### logic/pic_ctl_end.sv
// Interrupt controller: request flags, enables, priorities, vectoring and nesting.
`timescale 1ns/1ps
// What this block does
// - Eight sources, each on four levels.
// - Global enable gates every source enable.
// - Long call to vector after instruction ends.
// - Return resumes the interrupted instruction stream.
// - Flags set regardless; disabled ones ignored.
// - Level is high bit, low bit pair.
// - Lower levels never preempt a running routine.
// - Higher level wins among simultaneous requests.
// - Same level: fixed polling order, pin0 first.
// - Vectors 0003H upward in steps of eight.
// - External pins level or edge triggered.
// - Vectoring clears external flag only when edge.
// - Timer overflow flags cleared on vectoring.
// - Serial request ORs receive and transmit done.
// - Converter done flag, software clears it.
// - Low voltage flag, software clears it.
// - Counter array ORs three gated flags.
// - Software writes every flag like hardware, except external flags in level mode.
// - Enable bit one enables, zero disables.
// - Top level routine cannot be preempted.
module pic_ctl_end (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  sys_rst,
   // Link to the core
   pic_if.ctl         cpu,
   // External pins, active low, asynchronous
   input  wire logic  extPin0N,
   input  wire logic  extPin1N,
   // Peripheral events, one-cycle pulses on clk
   input  wire logic  timer0Ovf,
   input  wire logic  timer1Ovf,
   input  wire logic  rxDone,
   input  wire logic  txDone,
   input  wire logic  adcDone,
   input  wire logic  lowVoltEvt,
   input  wire logic  caOvf,
   input  wire logic  mod0Evt,
   input  wire logic  mod1Evt,
   // Status
   output logic [3:0] levelsInService
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [7:0]        enable;
      logic [7:0]        prioLo;
      logic [7:0]        prioHi;
      logic              x0Trig;
      logic              x1Trig;
      logic              x0Req;
      logic              x1Req;
      logic              t0Ovf;
      logic              t1Ovf;
      logic              rxDone;
      logic              txDone;
      logic              adcDone;
      logic              lowVolt;
      logic              caOvf;
      logic              m0Evt;
      logic              m1Evt;
      logic              caOvfEn;
      logic              m0EvtEn;
      logic              m1EvtEn;
      logic [2:0]        pin0Sync;
      logic [2:0]        pin1Sync;
      logic [3:0]        inSvc;
      logic              irqReq;
      pic_pkg::pic_src_t irqSrc;
      logic [15:0]       irqVector;
      logic [7:0]        rdata;
   } pic_ctl_state_t;

   pic_ctl_state_t    q;
   pic_ctl_state_t    d;
   logic [7:0]        req;
   logic              found;
   pic_pkg::pic_lvl_t bestLvl;
   pic_pkg::pic_src_t bestSrc;
   pic_pkg::pic_lvl_t actLvl;
   pic_pkg::pic_lvl_t ackLvl;
   logic              cleared;
   logic              pin0Fall;
   logic              pin1Fall;
   logic              wrTim;
   logic              ackT0;
   logic              ackT1;
   logic              ackX0;
   logic              ackX1;
   logic [7:0]        wd;

   // Hardware set takes precedence over any clear in the same cycle.
   function automatic logic flagNext(
      input logic cur,
      input logic set,
      input logic wr,
      input logic wbit,
      input logic clr
   );
      return set | (wr ? wbit : (cur & ~clr));
   endfunction : flagNext

   function automatic logic isWr(input logic [7:0] a, input logic [7:0] target);
      return cpu.sfrWr && (a == target);
   endfunction : isWr

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      d  = q;
      wd = cpu.sfrWdata;

      // The first synchroniser stage feeds only the second.
      d.pin0Sync = {q.pin0Sync[1:0], ~extPin0N};
      d.pin1Sync = {q.pin1Sync[1:0], ~extPin1N};
      pin0Fall   = q.pin0Sync[1] & ~q.pin0Sync[2];
      pin1Fall   = q.pin1Sync[1] & ~q.pin1Sync[2];

      if (isWr(cpu.sfrAddr, pic_pkg::ADDR_ENABLE))
         d.enable = wd;
      if (isWr(cpu.sfrAddr, pic_pkg::ADDR_PRIO_LO))
         d.prioLo = wd;
      if (isWr(cpu.sfrAddr, pic_pkg::ADDR_PRIO_HI))
         d.prioHi = wd;

      wrTim = isWr(cpu.sfrAddr, pic_pkg::ADDR_TIMCTL);
      if (wrTim)
      begin
         d.x0Trig = wd[pic_pkg::TC_X0TRIG_BIT];
         d.x1Trig = wd[pic_pkg::TC_X1TRIG_BIT];
      end

      ackX0 = cpu.irqAck && (cpu.ackSrc == pic_pkg::SRC_EXT0) && q.x0Trig;
      ackX1 = cpu.irqAck && (cpu.ackSrc == pic_pkg::SRC_EXT1) && q.x1Trig;
      ackT0 = cpu.irqAck && (cpu.ackSrc == pic_pkg::SRC_TIMER0);
      ackT1 = cpu.irqAck && (cpu.ackSrc == pic_pkg::SRC_TIMER1);

      // In level mode the pin owns the flag, so a software write there is overridden.
      d.x0Req = d.x0Trig ? flagNext(q.x0Req, pin0Fall, wrTim, wd[pic_pkg::TC_X0REQ_BIT], ackX0)
                         : q.pin0Sync[1];
      d.x1Req = d.x1Trig ? flagNext(q.x1Req, pin1Fall, wrTim, wd[pic_pkg::TC_X1REQ_BIT], ackX1)
                         : q.pin1Sync[1];
      d.t0Ovf = flagNext(q.t0Ovf, timer0Ovf, wrTim, wd[pic_pkg::TC_T0OVF_BIT], ackT0);
      d.t1Ovf = flagNext(q.t1Ovf, timer1Ovf, wrTim, wd[pic_pkg::TC_T1OVF_BIT], ackT1);

      // Remaining flags are never cleared by vectoring.
      d.rxDone  = flagNext(q.rxDone, rxDone, isWr(cpu.sfrAddr, pic_pkg::ADDR_SERCTL),
                           wd[pic_pkg::SC_RXDONE_BIT], 1'b0);
      d.txDone  = flagNext(q.txDone, txDone, isWr(cpu.sfrAddr, pic_pkg::ADDR_SERCTL),
                           wd[pic_pkg::SC_TXDONE_BIT], 1'b0);
      d.adcDone = flagNext(q.adcDone, adcDone, isWr(cpu.sfrAddr, pic_pkg::ADDR_ADCCTL),
                           wd[pic_pkg::ADC_DONE_BIT], 1'b0);
      d.lowVolt = flagNext(q.lowVolt, lowVoltEvt, isWr(cpu.sfrAddr, pic_pkg::ADDR_PWRCTL),
                           wd[pic_pkg::PC_LOWVOLT_BIT], 1'b0);
      d.caOvf   = flagNext(q.caOvf, caOvf, isWr(cpu.sfrAddr, pic_pkg::ADDR_CACTL),
                           wd[pic_pkg::CC_OVF_BIT], 1'b0);
      d.m0Evt   = flagNext(q.m0Evt, mod0Evt, isWr(cpu.sfrAddr, pic_pkg::ADDR_CACTL),
                           wd[pic_pkg::CC_M0EVT_BIT], 1'b0);
      d.m1Evt   = flagNext(q.m1Evt, mod1Evt, isWr(cpu.sfrAddr, pic_pkg::ADDR_CACTL),
                           wd[pic_pkg::CC_M1EVT_BIT], 1'b0);
      if (isWr(cpu.sfrAddr, pic_pkg::ADDR_CAMODE))
         d.caOvfEn = wd[pic_pkg::CM_OVFEN_BIT];
      if (isWr(cpu.sfrAddr, pic_pkg::ADDR_CAMOD0))
         d.m0EvtEn = wd[pic_pkg::CAM_EVTEN_BIT];
      if (isWr(cpu.sfrAddr, pic_pkg::ADDR_CAMOD1))
         d.m1EvtEn = wd[pic_pkg::CAM_EVTEN_BIT];

      // Pending flags stay set while disabled; only the request is masked.
      req[pic_pkg::SRC_EXT0]    = q.x0Req & q.enable[pic_pkg::SRC_EXT0];
      req[pic_pkg::SRC_TIMER0]  = q.t0Ovf & q.enable[pic_pkg::SRC_TIMER0];
      req[pic_pkg::SRC_EXT1]    = q.x1Req & q.enable[pic_pkg::SRC_EXT1];
      req[pic_pkg::SRC_TIMER1]  = q.t1Ovf & q.enable[pic_pkg::SRC_TIMER1];
      req[pic_pkg::SRC_SERIAL]  = (q.rxDone | q.txDone) & q.enable[pic_pkg::SRC_SERIAL];
      req[pic_pkg::SRC_ADC]     = q.adcDone & q.enable[pic_pkg::SRC_ADC];
      req[pic_pkg::SRC_LOWVOLT] = q.lowVolt & q.enable[pic_pkg::SRC_LOWVOLT];
      req[pic_pkg::SRC_CA]      = (q.caOvf & q.caOvfEn) | (q.m0Evt & q.m0EvtEn)
                                | (q.m1Evt & q.m1EvtEn);
      req = req & {pic_pkg::NUM_SRC{q.enable[pic_pkg::EN_GLOBAL_BIT]}};

      // Scan from last to first so equal levels fall to the lower index.
      found   = 1'b0;
      bestLvl = '0;
      bestSrc = '0;
      for (int i = pic_pkg::NUM_SRC - 1; i >= 0; i--)
      begin
         if (req[i] && (!found || ({q.prioHi[i], q.prioLo[i]} >= bestLvl)))
         begin
            found   = 1'b1;
            bestLvl = {q.prioHi[i], q.prioLo[i]};
            bestSrc = pic_pkg::pic_src_t'(i);
         end
      end

      actLvl = '0;
      for (int j = 0; j < pic_pkg::NUM_LVL; j++)
      begin
         if (q.inSvc[j])
            actLvl = pic_pkg::pic_lvl_t'(j);
      end

      // Only a strictly higher level may nest; a level three routine therefore is never preempted.
      d.irqReq    = found && ((q.inSvc == 4'h0) || (bestLvl > actLvl)) && !cpu.irqAck;
      d.irqSrc    = bestSrc;
      d.irqVector = (16'(bestSrc) << pic_pkg::VEC_STEP_LOG2) + pic_pkg::VEC_BASE;

      // Return releases the highest level in service, then a new call may claim one.
      cleared = 1'b0;
      if (cpu.retiExec)
      begin
         for (int k = pic_pkg::NUM_LVL - 1; k >= 0; k--)
         begin
            if (q.inSvc[k] && !cleared)
            begin
               d.inSvc[k] = 1'b0;
               cleared    = 1'b1;
            end
         end
      end
      ackLvl = {q.prioHi[cpu.ackSrc], q.prioLo[cpu.ackSrc]};
      if (cpu.irqAck)
         d.inSvc[ackLvl] = 1'b1;

      // Bits this block does not hold read as zero.
      case (cpu.sfrAddr)
         pic_pkg::ADDR_ENABLE:  d.rdata = q.enable;
         pic_pkg::ADDR_PRIO_LO: d.rdata = q.prioLo;
         pic_pkg::ADDR_PRIO_HI: d.rdata = q.prioHi;
         pic_pkg::ADDR_TIMCTL:  d.rdata = {q.t1Ovf, 1'b0, q.t0Ovf, 1'b0,
                                          q.x1Req, q.x1Trig, q.x0Req, q.x0Trig};
         pic_pkg::ADDR_SERCTL:  d.rdata = {6'h00, q.txDone, q.rxDone};
         pic_pkg::ADDR_ADCCTL:  d.rdata = 8'(q.adcDone) << pic_pkg::ADC_DONE_BIT;
         pic_pkg::ADDR_PWRCTL:  d.rdata = 8'(q.lowVolt) << pic_pkg::PC_LOWVOLT_BIT;
         pic_pkg::ADDR_CACTL:   d.rdata = {q.caOvf, 5'h00, q.m1Evt, q.m0Evt};
         pic_pkg::ADDR_CAMODE:  d.rdata = {7'h00, q.caOvfEn};
         pic_pkg::ADDR_CAMOD0:  d.rdata = {7'h00, q.m0EvtEn};
         pic_pkg::ADDR_CAMOD1:  d.rdata = {7'h00, q.m1EvtEn};
         default:               d.rdata = pic_pkg::REG_RESET;
      endcase
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         q <= '0;
      else
         q <= d;
   end

   assign cpu.irqReq      = q.irqReq;
   assign cpu.irqSrc      = q.irqSrc;
   assign cpu.irqVector   = q.irqVector;
   assign cpu.sfrRdata    = q.rdata;
   assign levelsInService = q.inSvc;

endmodule : pic_ctl_end

// ### logic/pic_if.sv
// Link between the interrupt controller and the core instruction sequencer.
`timescale 1ns/1ps
interface pic_if;

   // ************************************************************
   // Request, acknowledge and return
   // ************************************************************
   logic                irqReq;
   logic [15:0]         irqVector;
   pic_pkg::pic_src_t   irqSrc;
   logic                irqAck;
   pic_pkg::pic_src_t   ackSrc;
   logic                retiExec;

   // ************************************************************
   // Special function register access
   // ************************************************************
   logic                sfrWr;
   logic [7:0]          sfrAddr;
   logic [7:0]          sfrWdata;
   logic [7:0]          sfrRdata;

   modport ctl (
      output irqReq, irqVector, irqSrc, sfrRdata,
      input  irqAck, ackSrc, retiExec, sfrWr, sfrAddr, sfrWdata
   );

   modport cpu (
      input  irqReq, irqVector, irqSrc, sfrRdata,
      output irqAck, ackSrc, retiExec, sfrWr, sfrAddr, sfrWdata
   );

endinterface : pic_if

// ### logic/pic_pkg.sv
// Shared constants and types for the prioritized interrupt controller and its core end.
package pic_pkg;

   // ************************************************************
   // Sizes and types
   // ************************************************************
   localparam int NUM_SRC = 8;
   localparam int NUM_LVL = 4;
   typedef logic [1:0] pic_lvl_t;
   typedef logic [2:0] pic_src_t;

   // ************************************************************
   // Special function register addresses
   // ************************************************************
   localparam logic [7:0] ADDR_ENABLE  = 8'ha8;
   localparam logic [7:0] ADDR_PRIO_LO = 8'hb8;
   localparam logic [7:0] ADDR_PRIO_HI = 8'hb7;
   localparam logic [7:0] ADDR_TIMCTL  = 8'h88;
   localparam logic [7:0] ADDR_SERCTL  = 8'h98;
   localparam logic [7:0] ADDR_PWRCTL  = 8'h87;
   localparam logic [7:0] ADDR_ADCCTL  = 8'hbc;
   localparam logic [7:0] ADDR_CACTL   = 8'hd8;
   localparam logic [7:0] ADDR_CAMODE  = 8'hd9;
   localparam logic [7:0] ADDR_CAMOD0  = 8'hda;
   localparam logic [7:0] ADDR_CAMOD1  = 8'hdb;
   localparam logic [7:0] REG_RESET    = 8'h00;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int EN_GLOBAL_BIT  = 7;
   localparam int TC_T1OVF_BIT   = 7;
   localparam int TC_T0OVF_BIT   = 5;
   localparam int TC_X1REQ_BIT   = 3;
   localparam int TC_X1TRIG_BIT  = 2;
   localparam int TC_X0REQ_BIT   = 1;
   localparam int TC_X0TRIG_BIT  = 0;
   localparam int SC_TXDONE_BIT  = 1;
   localparam int SC_RXDONE_BIT  = 0;
   localparam int ADC_DONE_BIT   = 4;
   localparam int PC_LOWVOLT_BIT = 5;
   localparam int CC_OVF_BIT     = 7;
   localparam int CC_M1EVT_BIT   = 1;
   localparam int CC_M0EVT_BIT   = 0;
   localparam int CM_OVFEN_BIT   = 0;
   localparam int CAM_EVTEN_BIT  = 0;

   // ************************************************************
   // Sources in polling order and vectors
   // ************************************************************
   localparam pic_src_t SRC_EXT0    = 3'h0;
   localparam pic_src_t SRC_TIMER0  = 3'h1;
   localparam pic_src_t SRC_EXT1    = 3'h2;
   localparam pic_src_t SRC_TIMER1  = 3'h3;
   localparam pic_src_t SRC_SERIAL  = 3'h4;
   localparam pic_src_t SRC_ADC     = 3'h5;
   localparam pic_src_t SRC_LOWVOLT = 3'h6;
   localparam pic_src_t SRC_CA      = 3'h7;
   localparam logic [15:0] VEC_BASE      = 16'h0003;
   localparam int          VEC_STEP_LOG2 = 3;

endpackage : pic_pkg

// ### tb/pic_properties.sv
// Concurrent checks on the link between the interrupt controller and the core end.
`timescale 1ns/1ps
module pic_properties (
   // Clock and reset
   input wire logic              clk,
   input wire logic              sys_rst,
   // Controller to core
   input wire logic              irqReq,
   input wire logic [15:0]       irqVector,
   input wire pic_pkg::pic_src_t irqSrc,
   input wire logic [7:0]        sfrRdata,
   input wire logic [3:0]        levelsInService,
   // Core to controller
   input wire logic              irqAck,
   input wire pic_pkg::pic_src_t ackSrc,
   input wire logic              retiExec,
   input wire logic              sfrWr,
   input wire logic [7:0]        sfrAddr,
   input wire logic [7:0]        sfrWdata
);
   // ************************************************************
   // Shadows of the enable and level registers
   // ************************************************************
   logic [7:0] en_q, lo_q, hi_q, enOld_q, loOld_q, hiOld_q;
   logic [3:0] lisOld_q, lisRel;
   logic [1:0] reqLvl, ackLvl, topOld;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         {en_q, lo_q, hi_q, enOld_q, loOld_q, hiOld_q, lisOld_q} <= '0;
      end
      else
      begin
         if (sfrWr && sfrAddr == pic_pkg::ADDR_ENABLE) en_q <= sfrWdata;
         if (sfrWr && sfrAddr == pic_pkg::ADDR_PRIO_LO) lo_q <= sfrWdata;
         if (sfrWr && sfrAddr == pic_pkg::ADDR_PRIO_HI) hi_q <= sfrWdata;
         {enOld_q, loOld_q, hiOld_q, lisOld_q} <= {en_q, lo_q, hi_q, levelsInService};
      end
   end

   // The request is registered, so it is judged against settings one cycle old.
   assign reqLvl = {hiOld_q[irqSrc], loOld_q[irqSrc]};
   assign ackLvl = {hi_q[ackSrc], lo_q[ackSrc]};
   assign topOld = lisOld_q[3] ? 2'h3 : lisOld_q[2] ? 2'h2 : {1'b0, lisOld_q[1]};
   assign lisRel = levelsInService[3] ? {1'b0, levelsInService[2:0]} :
                   levelsInService[2] ? {2'h0, levelsInService[1:0]} :
                   {3'h0, levelsInService[1] & levelsInService[0]};

   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   vector_map_a:
      assert property (irqReq |-> irqVector == 16'h0003 + {10'h0, irqSrc, 3'h0})
      else $error("Vector does not match the selected source.");
   global_gate_a:
      assert property (irqReq |-> enOld_q[7])
      else $error("Request raised with the global enable off.");
   source_gate_a:
      assert property (irqReq && irqSrc != pic_pkg::SRC_CA |-> enOld_q[irqSrc])
      else $error("Request raised for a disabled source.");
   preempt_block_a:
      assert property (irqReq |-> lisOld_q == 4'h0 || reqLvl > topOld)
      else $error("Request does not outrank the level in service.");
   top_level_a:
      assert property (lisOld_q[3] |-> !irqReq)
      else $error("Request raised while the top level is in service.");
   ack_follows_a:
      assert property (irqAck |-> $past(irqReq) && ackSrc == $past(irqSrc))
      else $error("Acknowledge without a matching request.");
   level_track_a:
      assert property (irqAck |=> levelsInService[$past(ackLvl)])
      else $error("Acknowledged level not marked in service.");
   return_from_interrupt_release_a:
      assert property (retiExec && !irqAck |=> levelsInService == $past(lisRel))
      else $error("Return did not release exactly the top level.");
   read_mirror_a:
      assert property (sfrAddr == pic_pkg::ADDR_ENABLE |=> sfrRdata == $past(en_q))
      else $error("Enable register read back differs from the last write.");

   cover property (irqAck && levelsInService != 4'h0);
   cover property (retiExec);
   cover property (irqReq && reqLvl == 2'h3);

endmodule : pic_properties

// ### tb/prioritized_interrupt_controller_test.sv
// Self-checking bench joining the interrupt controller and the core end.
`timescale 1ns/1ps
module prioritized_interrupt_controller_test;
   // ************************************************************
   // Signals and instances
   // ************************************************************
   localparam logic [7:0] aEn  = pic_pkg::ADDR_ENABLE;
   localparam logic [7:0] aLo  = pic_pkg::ADDR_PRIO_LO;
   localparam logic [7:0] aHi  = pic_pkg::ADDR_PRIO_HI;
   localparam logic [7:0] aTim = pic_pkg::ADDR_TIMCTL;
   localparam logic [7:0] aSer = pic_pkg::ADDR_SERCTL;
   localparam logic [7:0] aAdc = pic_pkg::ADDR_ADCCTL;
   localparam logic [7:0] aPwr = pic_pkg::ADDR_PWRCTL;
   localparam logic [7:0] aCa  = pic_pkg::ADDR_CACTL;
   logic        clk, sys_rst, seqInstrEnd, seqReti, swWr, callGo;
   logic [7:0]  swAddr, swWdata, swRdata, lo, hi, en, m;
   logic [15:0] callAddr;
   logic [3:0]  levelsInService, w;
   logic [1:0]  pinN;
   logic [8:0]  evt;
   logic [31:0] seed;
   logic [7:0]  addrs [11];
   logic [7:0]  masks [11];
   int          mismatches, tests_run;
   pic_if link ();

   pic_ctl_end i_pic_ctl_end (.clk(clk), .sys_rst(sys_rst), .cpu(link.ctl),
      .extPin0N(pinN[0]), .extPin1N(pinN[1]), .timer0Ovf(evt[0]), .timer1Ovf(evt[1]),
      .rxDone(evt[2]), .txDone(evt[3]), .adcDone(evt[4]), .lowVoltEvt(evt[5]),
      .caOvf(evt[6]), .mod0Evt(evt[7]), .mod1Evt(evt[8]), .levelsInService(levelsInService));
   pic_cpu_end i_pic_cpu_end (.clk(clk), .sys_rst(sys_rst), .ctl(link.cpu),
      .seqInstrEnd(seqInstrEnd), .seqReti(seqReti), .swWr(swWr), .swAddr(swAddr),
      .swWdata(swWdata), .callGo(callGo), .callAddr(callAddr), .swRdata(swRdata));
   pic_properties i_pic_properties (.clk(clk), .sys_rst(sys_rst), .irqReq(link.irqReq),
      .irqVector(link.irqVector), .irqSrc(link.irqSrc), .sfrRdata(link.sfrRdata),
      .levelsInService(levelsInService), .irqAck(link.irqAck), .ackSrc(link.ackSrc),
      .retiExec(link.retiExec), .sfrWr(link.sfrWr), .sfrAddr(link.sfrAddr),
      .sfrWdata(link.sfrWdata));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   // Walking down with >= lets the lower index win a tie.
   function automatic logic [3:0] pick(input logic [7:0] r, input logic [7:0] l,
                                       input logic [7:0] h);
      logic [3:0] b;
      b = 4'h0;
      for (int i = 7; i >= 0; i--)
         if (r[i] && (!b[3] || {h[i], l[i]} >= {h[b[2:0]], l[b[2:0]]}))
            b = {1'b1, 3'(i)};
      return b;
   endfunction : pick

   task report_and_stop;
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop

   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task tick;
      @(posedge clk);
      #2;
   endtask : tick

   task wr(input logic [7:0] a, input logic [7:0] d);
      swAddr = a;
      swWdata = d;
      swWr = 1'b1;
      tick();
      swWr = 1'b0;
      tick();
   endtask : wr

   task rdChk(input logic [7:0] a, input logic [7:0] e);
      swAddr = a;
      repeat (3) tick();
      check("register read", {8'h0, swRdata}, {8'h0, e});
   endtask : rdChk

   task lisChk(input logic [3:0] e);
      check("levels in service", {12'h0, levelsInService}, {12'h0, e});
   endtask : lisChk

   task fire(input logic [8:0] e, input logic [1:0] p);
      evt = e;
      pinN = ~p;
      tick();
      evt = '0;
      repeat (2) tick();
      pinN = 2'h3;
      repeat (4) tick();
   endtask : fire

   task automatic call(input logic want, input logic [15:0] exp);
      int n;
      n = 0;
      seqInstrEnd = 1'b1;
      while (n < 12 && callGo !== 1'b1)
      begin
         tick();
         n++;
      end
      seqInstrEnd = 1'b0;
      check("call taken", {15'h0, callGo}, {15'h0, want});
      if (want && callGo !== 1'b1)
         report_and_stop();
      else if (want)
         check("call address", callAddr, exp);
      tick();
   endtask : call

   task ret;
      seqReti = 1'b1;
      tick();
      seqReti = 1'b0;
      repeat (2) tick();
   endtask : ret

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      {sys_rst, seqInstrEnd, seqReti, swWr, swAddr, swWdata} = {1'b1, 19'h0};
      {pinN, evt, seed, mismatches, tests_run} = {2'h3, 9'h0, 32'h2b30, 64'h0};
      addrs = '{aEn, aLo, aHi, aTim, aSer, aAdc, aPwr, aCa, pic_pkg::ADDR_CAMODE,
                pic_pkg::ADDR_CAMOD0, pic_pkg::ADDR_CAMOD1};
      masks = '{8'hff, 8'hff, 8'hff, 8'haf, 8'h03, 8'h10, 8'h20, 8'h83, 8'h01, 8'h01, 8'h01};
      repeat (8) @(posedge clk);
      #2 sys_rst = 1'b0;
      tick();
      for (int i = 0; i < 11; i++)
      begin
         rdChk(addrs[i], 8'h00);
         wr(addrs[i], 8'hff);
         rdChk(addrs[i], masks[i]);
         wr(addrs[i], 8'h00);
      end
      wr(8'h80, 8'hff);
      rdChk(8'h80, 8'h00);
      // Gating: a pending flag waits until both enables are on.
      fire(9'h001, 2'h0);
      rdChk(aTim, 8'h20);
      call(1'b0, 16'h0);
      wr(aEn, 8'h02);
      call(1'b0, 16'h0);
      wr(aEn, 8'h80);
      call(1'b0, 16'h0);
      wr(aEn, 8'h82);
      call(1'b1, 16'h000b);
      rdChk(aTim, 8'h00);
      ret();
      wr(aEn, 8'ha0);
      wr(aAdc, 8'h10);
      call(1'b1, 16'h002b);
      rdChk(aAdc, 8'h10);
      wr(aAdc, 8'h00);
      ret();
      // Nesting: timer0 on level 1, converter and low voltage on 3.
      wr(aLo, 8'h62);
      wr(aHi, 8'h60);
      wr(aEn, 8'hf2);
      fire(9'h001, 2'h0);
      call(1'b1, 16'h000b);
      lisChk(4'h2);
      fire(9'h004, 2'h0);
      call(1'b0, 16'h0);
      fire(9'h010, 2'h0);
      call(1'b1, 16'h002b);
      wr(aAdc, 8'h00);
      lisChk(4'ha);
      fire(9'h020, 2'h0);
      call(1'b0, 16'h0);
      ret();
      lisChk(4'h2);
      call(1'b1, 16'h0033);
      wr(aPwr, 8'h00);
      ret();
      ret();
      lisChk(4'h0);
      call(1'b1, 16'h0023);
      rdChk(aSer, 8'h01);
      wr(aSer, 8'h00);
      ret();
      // Level mode: the flag follows the pin and survives vectoring.
      wr(aLo, 8'h00);
      wr(aHi, 8'h00);
      wr(aEn, 8'h84);
      pinN = 2'h1;
      call(1'b1, 16'h0013);
      rdChk(aTim, 8'h08);
      pinN = 2'h3;
      repeat (4) tick();
      rdChk(aTim, 8'h00);
      ret();
      wr(pic_pkg::ADDR_CAMODE, 8'h01);
      wr(pic_pkg::ADDR_CAMOD0, 8'h01);
      wr(pic_pkg::ADDR_CAMOD1, 8'h01);
      repeat (24)
      begin
         seed = xs(seed);
         {en, hi, lo} = {seed[23:16] | 8'h80, seed[15:0]};
         seed = xs(seed);
         m = seed[7:0];
         wr(aTim, 8'h05);
         wr(aSer, 8'h00);
         wr(aAdc, 8'h00);
         wr(aPwr, 8'h00);
         wr(aCa, 8'h00);
         wr(aLo, lo);
         wr(aHi, hi);
         wr(aEn, en);
         fire({m[7] & ~seed[9] & ~seed[10], m[7] & ~seed[9] & seed[10], m[7] & seed[9],
               m[6], m[5], m[4] & ~seed[8], m[4] & seed[8], m[3], m[1]}, {m[2], m[0]});
         w = pick(m & {1'b1, en[6:0]}, lo, hi);
         call(w[3], 16'h0003 + {10'h0, w[2:0], 3'h0});
         if (w[3])
         begin
            lisChk(4'h1 << {hi[w[2:0]], lo[w[2:0]]});
            rdChk(aTim, {m[3] && w[2:0] != 3'h3, 1'b0, m[1] && w[2:0] != 3'h1, 1'b0,
                         m[2] && w[2:0] != 3'h2, 1'b1, m[0] && w[2:0] != 3'h0, 1'b1});
            rdChk(aSer, {6'h0, m[4] & ~seed[8], m[4] & seed[8]});
            ret();
         end
      end
      report_and_stop();
   end

endmodule : prioritized_interrupt_controller_test
